// ---- logic/pool_arbiter_params.svh ----
// Purpose: Constants for the slave port pool arbiter
// Assumes: Four masters, four pool levels, 8-bit slot count
// Notes:   Masters 0 and 1 are the processor core masters
`ifndef POOL_ARBITER_PARAMS_SVH
`define POOL_ARBITER_PARAMS_SVH
`define NUM_MASTERS    4
`define LEVEL_LOW      2'h0
`define LEVEL_HIGH     2'h3
`define POOL_RESET     8'h0F
`define SLOT_RESET     8'hFF
`define CORE_MASTERS   2
`endif

// ---- logic/pool_arbiter_pkg.sv ----
// Purpose: Types for the slave port pool arbiter
// Assumes: Widths match the params header
// Notes:   No constants live here, only types
`default_nettype none
package pool_arbiter_pkg;
  typedef logic [1:0] level_type;
  typedef logic [1:0] idx_type;
  typedef logic [7:0] slot_type;
  typedef logic [3:0] vec_type;
endpackage
`default_nettype wire

// ---- logic/slave_port_pool_arbiter.sv ----
// Purpose: Per-slave arbiter of a multi-master crossbar with priority pools
// Assumes: Requests and access-end strobes are synchronous to sys_clk_i
// Notes:   Configuration arrives on plain ports, there is no register bus
// Function
// - Load slot counter per grant, count down
// - Expired counter rearbitrates at access end only
// - Always wait for current access to finish
// - Round-robin top and bottom, fixed elsewhere
// - Pool level overrides all but the last owner stepping aside
// - Non-core masters reset to level zero
// - Top pool fair round-robin, bounded latency
// - Larger level means higher priority
// - Any level combination is accepted
// - No repeat grant while others request
// - Back-to-back only for sole requester
`timescale 1ns/1ps
`default_nettype none
`include "pool_arbiter_params.svh"

module slave_port_pool_arbiter
(
  input  wire logic                       sys_clk_i,
  input  wire logic                       reset_i,
  input  wire pool_arbiter_pkg::vec_type  req_i,
  input  wire logic                       access_end_i,
  input  wire logic                       run_end_i,
  input  wire logic                       cfg_we_i,
  input  wire logic [7:0]                 cfg_level_i,
  input  wire pool_arbiter_pkg::slot_type cfg_slot_i,
  output logic [3:0]                      grant_o,
  output logic                            owner_valid_o,
  output logic                            slot_expired_o
);

  // ************************************************************
  // Configuration state
  // ************************************************************
  logic [7:0]                 master_pool_level;
  pool_arbiter_pkg::slot_type slot_config_reg;

  // ************************************************************
  // Arbitration state
  // ************************************************************
  pool_arbiter_pkg::idx_type  owner;
  logic                       have_last;
  pool_arbiter_pkg::idx_type  last_hi;
  pool_arbiter_pkg::idx_type  last_lo;
  pool_arbiter_pkg::slot_type slot_count;
  logic                       slot_armed;

  // ************************************************************
  // Selection helpers
  // ************************************************************
  // Round-robin: first candidate after the last winner of the pool
  function automatic pool_arbiter_pkg::idx_type rr_pick
  (
    input pool_arbiter_pkg::vec_type v,
    input pool_arbiter_pkg::idx_type last
  );
    pool_arbiter_pkg::idx_type j;
    pool_arbiter_pkg::idx_type r;
    logic                      found;
    r = last;
    found = 1'b0;
    for (int k = 1; k <= `NUM_MASTERS; k++)
    begin
      j = last + k[1:0];
      if (!found && v[j])
      begin
        r = j;
        found = 1'b1;
      end
    end
    return r;
  endfunction

  // Fixed order inside intermediate pools: lowest index wins
  function automatic pool_arbiter_pkg::idx_type fixed_pick
  (
    input pool_arbiter_pkg::vec_type v
  );
    pool_arbiter_pkg::idx_type r;
    r = 2'h0;
    for (int k = `NUM_MASTERS - 1; k >= 0; k--)
    begin
      if (v[k])
      begin
        r = k[1:0];
      end
    end
    return r;
  endfunction

  // Highest level among the eligible requesters
  function automatic pool_arbiter_pkg::level_type top_of
  (
    input pool_arbiter_pkg::vec_type v,
    input logic [7:0]                lv
  );
    pool_arbiter_pkg::level_type t;
    t = `LEVEL_LOW;
    for (int k = 0; k < `NUM_MASTERS; k++)
    begin
      if (v[k] && lv[2*k +: 2] > t)
      begin
        t = lv[2*k +: 2];
      end
    end
    return t;
  endfunction

  // ************************************************************
  // Decision logic
  // ************************************************************
  wire pool_arbiter_pkg::vec_type   last_onehot = have_last ? (4'h1 << owner) : 4'h0;
  wire pool_arbiter_pkg::vec_type   others      = req_i & ~last_onehot;
  // The previous owner steps aside whenever anyone else waits
  wire pool_arbiter_pkg::vec_type   elig        = (others != 4'h0) ? others : req_i;
  wire logic                        any_elig    = (elig != 4'h0);
  wire pool_arbiter_pkg::level_type top_level   = top_of(elig, master_pool_level);
  wire pool_arbiter_pkg::vec_type   cand;
  // Only the requesters of the winning pool compete further
  for (genvar g = 0; g < `NUM_MASTERS; g++)
  begin : g_cand
    assign cand[g] = elig[g] && (master_pool_level[2*g +: 2] == top_level);
  end
  wire logic is_high = (top_level == `LEVEL_HIGH);
  wire logic is_low  = (top_level == `LEVEL_LOW);
  wire pool_arbiter_pkg::idx_type winner =
    is_high ? rr_pick(cand, last_hi) :
    is_low  ? rr_pick(cand, last_lo) :
    fixed_pick(cand);

  // Rearbitrate only when idle or when the running access completes,
  // so a stuck access is never cut short
  wire logic rearb_point = !owner_valid_o ||
                           (access_end_i && (run_end_i || slot_expired_o));
  wire logic arb_fire    = rearb_point && any_elig;
  wire logic release_now = rearb_point && !any_elig && owner_valid_o;

  // ************************************************************
  // Slot counter
  // ************************************************************
  // Zero disables the limit: the counter never arms
  wire pool_arbiter_pkg::slot_type next_slot_count =
    arb_fire ? slot_config_reg :
    (slot_count != 8'h00) ? slot_count - 8'h01 : slot_count;
  wire logic next_slot_armed = arb_fire ? (slot_config_reg != 8'h00) :
                               (release_now ? 1'b0 : slot_armed);
  wire logic next_expired    = next_slot_armed && (next_slot_count == 8'h00);

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      master_pool_level <= `POOL_RESET;
      slot_config_reg   <= `SLOT_RESET;
    end
    else if (cfg_we_i)
    begin
      master_pool_level <= cfg_level_i;
      slot_config_reg   <= cfg_slot_i;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      slot_count     <= 8'h00;
      slot_armed     <= 1'b0;
      slot_expired_o <= 1'b0;
    end
    else
    begin
      slot_count     <= next_slot_count;
      slot_armed     <= next_slot_armed;
      slot_expired_o <= next_expired;
    end
  end

  // ************************************************************
  // Grant registers
  // ************************************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      owner         <= 2'h0;
      have_last     <= 1'b0;
      owner_valid_o <= 1'b0;
      grant_o       <= 4'h0;
    end
    else if (arb_fire)
    begin
      owner         <= winner;
      have_last     <= 1'b1;
      owner_valid_o <= 1'b1;
      grant_o       <= 4'h1 << winner;
    end
    else if (release_now)
    begin
      owner_valid_o <= 1'b0;
      grant_o       <= 4'h0;
    end
  end

  // Each round-robin pool remembers its own last winner
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      last_hi <= 2'h3;
      last_lo <= 2'h3;
    end
    else if (arb_fire && is_high)
    begin
      last_hi <= winner;
    end
    else if (arb_fire && is_low)
    begin
      last_lo <= winner;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  wire pool_arbiter_pkg::level_type owner_level = master_pool_level[2*owner +: 2];

  property p_slot_load;
    @(posedge sys_clk_i) disable iff (reset_i)
    arb_fire |=> (slot_count == $past(slot_config_reg));
  endproperty
  a_slot_load: assert property (p_slot_load)
    else $error("slot counter not loaded on grant");

  property p_slot_dec;
    @(posedge sys_clk_i) disable iff (reset_i)
    (slot_count != 8'h00) && !arb_fire |=> (slot_count == $past(slot_count) - 8'h01);
  endproperty
  a_slot_dec: assert property (p_slot_dec)
    else $error("slot counter did not count down");

  property p_hold_access;
    @(posedge sys_clk_i) disable iff (reset_i)
    owner_valid_o && !access_end_i |=> $stable(grant_o) && owner_valid_o;
  endproperty
  a_hold_access: assert property (p_hold_access)
    else $error("grant moved before access end");

  property p_no_break_early;
    @(posedge sys_clk_i) disable iff (reset_i)
    (owner_valid_o && slot_expired_o && !access_end_i) [*2] |-> $stable(grant_o);
  endproperty
  a_no_break_early: assert property (p_no_break_early)
    else $error("expired slot broke an access in progress");

  property p_level_first;
    @(posedge sys_clk_i) disable iff (reset_i)
    arb_fire && !cfg_we_i |=> (owner_level == $past(top_level));
  endproperty
  a_level_first: assert property (p_level_first)
    else $error("granted master not in top requesting pool");

  property p_higher_wins;
    @(posedge sys_clk_i) disable iff (reset_i)
    arb_fire && elig[0] && elig[1] && !cfg_we_i &&
    (master_pool_level[1:0] > master_pool_level[3:2]) |=> !grant_o[1];
  endproperty
  a_higher_wins: assert property (p_higher_wins)
    else $error("lower level beat higher level");

  property p_reset_levels;
    @(posedge sys_clk_i)
    reset_i |=> (master_pool_level[7:4] == 4'h0);
  endproperty
  a_reset_levels: assert property (p_reset_levels)
    else $error("non-core master not in lowest pool after reset");

  property p_no_repeat;
    @(posedge sys_clk_i) disable iff (reset_i)
    arb_fire && (others != 4'h0) && have_last |=> (owner != $past(owner));
  endproperty
  a_no_repeat: assert property (p_no_repeat)
    else $error("same master granted twice while others wait");

  property p_sole_keeps;
    @(posedge sys_clk_i) disable iff (reset_i)
    arb_fire && have_last && (req_i == last_onehot) |=> (owner == $past(owner));
  endproperty
  a_sole_keeps: assert property (p_sole_keeps)
    else $error("sole requester lost back-to-back grant");

  property p_top_rr;
    @(posedge sys_clk_i) disable iff (reset_i)
    arb_fire && is_high && (cand != (4'h1 << last_hi)) |=> (owner != $past(last_hi));
  endproperty
  a_top_rr: assert property (p_top_rr)
    else $error("top pool did not rotate");

  property p_onehot;
    @(posedge sys_clk_i) disable iff (reset_i)
    $onehot0(grant_o) && (owner_valid_o == (grant_o != 4'h0));
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("grant vector malformed");

  property p_low_share;
    @(posedge sys_clk_i) disable iff (reset_i)
    arb_fire && is_low && !cfg_we_i |=> (owner_level == `LEVEL_LOW);
  endproperty
  a_low_share: assert property (p_low_share)
    else $error("lowest pool share not granted");

  c_slot_break: cover property (@(posedge sys_clk_i) disable iff (reset_i)
    slot_expired_o && access_end_i && !run_end_i && (others != 4'h0));
  c_top_rotate: cover property (@(posedge sys_clk_i) disable iff (reset_i)
    arb_fire && is_high && ($countones(cand) > 1));
  c_inter_pool: cover property (@(posedge sys_clk_i) disable iff (reset_i)
    arb_fire && !is_high && !is_low);
  c_sole_again: cover property (@(posedge sys_clk_i) disable iff (reset_i)
    arb_fire && have_last && (req_i == last_onehot));

endmodule
`default_nettype wire

// ---- testbench/slave_access_model.sv ----
// Purpose: Slave side of the port, ends accesses and runs
// Assumes: One access lasts wait_i + 1 cycles once owned, the end strobe in the last
// Notes:   A large wait_i models a stalling slave
`timescale 1ns/1ps
`default_nettype none
module slave_access_model
(
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       owner_valid_i,
  input  wire logic [7:0] wait_i,
  input  wire logic [7:0] beats_i,
  output logic            access_end_o,
  output logic            run_end_o
);
  logic [7:0] cnt;
  logic [7:0] beat;

  // beats_i of zero ends a run only after 256 accesses, so slot expiry can break it first
  always_ff @(posedge clk_i)
  begin
    if (reset_i || !owner_valid_i || access_end_o)
    begin
      cnt          <= 8'h00;
      access_end_o <= 1'b0;
      run_end_o    <= 1'b0;
      beat         <= (reset_i || run_end_o || !owner_valid_i) ? 8'h00 : beat + 8'h01;
    end
    else
    begin
      cnt          <= cnt + 8'h01;
      access_end_o <= (cnt + 8'h01 == wait_i);
      run_end_o    <= (cnt + 8'h01 == wait_i) && (beat + 8'h01 == beats_i);
    end
  end
endmodule
`default_nettype wire

// ---- testbench/slave_port_pool_arbiter_test.sv ----
// Purpose: Self-checking bench of the slave port pool arbiter
// Assumes: Inputs change at the falling edge
// Notes:   Expected grant orders are worked out by hand per row
`timescale 1ns/1ps
`default_nettype none
module slave_port_pool_arbiter_test;
  logic       clk;
  logic       rst;
  logic [3:0] req;
  logic       ae;
  logic       re;
  logic       cfg_we;
  logic [7:0] cfg_lv;
  logic [7:0] cfg_slot;
  logic [3:0] grant;
  logic       ov;
  logic       se;
  logic [7:0] wait_c;
  logic [7:0] beats_c;
  int         error_cnt;
  int         n_tests;
  // Levels, requests, then four grants, first in the top nibble
  logic [27:0] rows [6] = '{28'h00F1248, 28'h69F2424, 28'hF3F1481,
                            28'h0CD4814, 28'h0088888, 28'h1074142};

  slave_port_pool_arbiter DUT (.sys_clk_i(clk), .reset_i(rst), .req_i(req),
    .access_end_i(ae), .run_end_i(re), .cfg_we_i(cfg_we), .cfg_level_i(cfg_lv),
    .cfg_slot_i(cfg_slot), .grant_o(grant), .owner_valid_o(ov), .slot_expired_o(se));

  slave_access_model slave (.clk_i(clk), .reset_i(rst), .owner_valid_i(ov),
    .wait_i(wait_c), .beats_i(beats_c), .access_end_o(ae), .run_end_o(re));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Looks at settled values on falling edges only, so no race with the
  // registers that the rising edge updates
  task automatic next_grant;
    int k;
    k = 0;
    while (ov && !(ae && re) && k < 60)
    begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    if (k == 60)
    begin
      error_cnt++;
      complete_run();
    end
  endtask

  // Config is loaded a cycle before requests so idle grants see it
  task automatic run_row(input logic wr, input logic [7:0] lv, input logic [3:0] rq,
                         input logic [7:0] sl, input logic [15:0] ex);
    cfg_we = wr;
    cfg_lv = lv;
    cfg_slot = sl;
    @(negedge clk);
    cfg_we = 1'b0;
    req = rq;
    for (int i = 3; i >= 0; i--)
    begin
      next_grant();
      check("grant", {4'h0, grant}, {4'h0, ex[4*i +: 4]});
      check("owner", {7'h00, ov}, 8'h01);
    end
  endtask

  // Cycles from a grant to expiry and to the next owner
  task automatic measure(input logic [7:0] e, input logic [7:0] c);
    logic [3:0] g;
    logic [7:0] k;
    logic [7:0] ke;
    g = grant;
    k = 8'h00;
    ke = 8'h00;
    while (grant === g && k < 8'h28)
    begin
      @(negedge clk);
      k++;
      if (se === 1'b1 && ke == 8'h00)
        ke = k;
    end
    check("expiry", ke, e);
    check("hold", k, c);
    check("next", {4'h0, grant}, {4'h0, g ^ 4'h3});
    if (k == 8'h28)
    begin
      error_cnt++;
      complete_run();
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    rst = 1'b1;
    req = 4'h0;
    cfg_we = 1'b0;
    cfg_lv = 8'h00;
    cfg_slot = 8'h00;
    wait_c = 8'h01;
    beats_c = 8'h01;
    error_cnt = 0;
    n_tests = 0;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      run_row(1'b1, rows[i][27:20], rows[i][19:16], 8'h00, rows[i][15:0]);
      $display("row %0d done", i);
    end
    rst = 1'b1;
    req = 4'h0;
    repeat (2) @(negedge clk);
    check("reset", {grant, 2'h0, ov, se}, 8'h00);
    rst = 1'b0;
    run_row(1'b0, 8'h00, 4'hF, 8'h00, 16'h1212);
    $display("reset test done");
    run_row(1'b1, 8'h00, 4'h3, 8'h02, 16'h1212);
    beats_c = 8'h00;
    measure(8'h02, 8'h04);
    wait_c = 8'h0C;
    measure(8'h02, 8'h0D);
    $display("slot test done");
    complete_run();
  end
endmodule
`default_nettype wire
